// >>> common/pwc_pkg.sv
// Purpose: Shared constants for the periodic wakeup counter.
// Assumes: 8-bit register port, 200 MHz bus clock.
// Notes: Offsets are word indices on the plain register port.
package pwc_pkg;
    localparam int ADDR_W = 2;
    localparam logic [1:0] OFS_CTRL = 2'h0;
    localparam logic [1:0] OFS_COUNT = 2'h1;
    localparam logic [1:0] OFS_MATCH = 2'h2;
    localparam int FLAG_BIT = 7;
    localparam int SRC_HI = 6;
    localparam int SRC_LO = 5;
    localparam int IE_BIT = 4;
    localparam int SEL_HI = 3;
    localparam int SEL_LO = 0;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [3:0] SEL_OFF = 4'h0;
    localparam logic [1:0] SRC_LPO = 2'h0;
    localparam logic [1:0] SRC_EXT = 2'h1;
    localparam int DIV_W = 18;
    localparam logic [DIV_W-1:0] DIV_ONE = 18'h0_0001;
endpackage

// >>> rtl/pwc_divider.sv
// Purpose: Prescaler that turns source-clock ticks into count pulses.
// Assumes: Source ticks arrive as one-cycle pulses on clk_in.
// Notes: Ratio table is selected by the low bit of the source field.
`timescale 1ns/1ps
module pwc_divider (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic clear_in,
    input wire logic freeze_in,
    input wire logic tick_in,
    input wire logic table_in,
    input wire logic [3:0] sel_in,
    output logic pulse_out
);
    logic [pwc_pkg::DIV_W-1:0] div_r;
    logic [pwc_pkg::DIV_W-1:0] ratio;

    // Ratio lookup; a select of zero means off and is never used as a ratio.
    function automatic logic [pwc_pkg::DIV_W-1:0] ratio_of(input logic tbl, input logic [3:0] sel);
        logic [pwc_pkg::DIV_W-1:0] r;
        r = pwc_pkg::DIV_ONE;
        if (!tbl) begin
            case (sel)
                4'h1: r = 18'h0_0008;
                4'h2: r = 18'h0_0020;
                4'h3: r = 18'h0_0040;
                4'h4: r = 18'h0_0080;
                4'h5: r = 18'h0_0100;
                4'h6: r = 18'h0_0200;
                4'h7: r = 18'h0_0400;
                4'h8: r = 18'h0_0001;
                4'h9: r = 18'h0_0002;
                4'hA: r = 18'h0_0004;
                4'hB: r = 18'h0_000A;
                4'hC: r = 18'h0_0010;
                4'hD: r = 18'h0_0064;
                4'hE: r = 18'h0_01F4;
                4'hF: r = 18'h0_03E8;
                default: r = pwc_pkg::DIV_ONE;
            endcase
        end else begin
            case (sel)
                4'h1: r = 18'h0_0400;
                4'h2: r = 18'h0_0800;
                4'h3: r = 18'h0_1000;
                4'h4: r = 18'h0_2000;
                4'h5: r = 18'h0_4000;
                4'h6: r = 18'h0_8000;
                4'h7: r = 18'h1_0000;
                4'h8: r = 18'h0_03E8;
                4'h9: r = 18'h0_07D0;
                4'hA: r = 18'h0_1388;
                4'hB: r = 18'h0_2710;
                4'hC: r = 18'h0_4E20;
                4'hD: r = 18'h0_C350;
                4'hE: r = 18'h1_86A0;
                4'hF: r = 18'h3_0D40;
                default: r = pwc_pkg::DIV_ONE;
            endcase
        end
        return r;
    endfunction

    assign ratio = ratio_of(table_in, sel_in);

    // Divider counts source ticks; the last tick of a period emits one pulse.
    always_ff @(posedge clk_in) begin
        if (srst_in || clear_in || sel_in == pwc_pkg::SEL_OFF) begin
            div_r <= '0;
            pulse_out <= 1'b0;
        end else if (tick_in && !freeze_in) begin
            if (div_r == ratio - pwc_pkg::DIV_ONE) begin
                div_r <= '0;
                pulse_out <= 1'b1;
            end else begin
                div_r <= div_r + pwc_pkg::DIV_ONE;
                pulse_out <= 1'b0;
            end
        end else begin
            pulse_out <= 1'b0;
        end
    end
endmodule // pwc_divider

// >>> rtl/pwc_top.sv
// Purpose: Periodic wakeup counter: 8-bit modulo counter with prescaler and match event.
// Assumes: Source clocks arrive as level signals from outside this clock domain.
// Notes: Each source is synchronised and edge-detected, so it must be well below 100 MHz.
`timescale 1ns/1ps
// Behaviour
// - 8-bit counter steps on prescaler pulses.
// - At match, wrap to zero and set flag.
// - Match limit zero flags every pulse.
// - Writing one clears flag; zero ignored.
// - Request high when enable and flag set.
// - Source field chooses prescaler input clock.
// - Changed source clears divider and counter.
// - Changed select clears divider and counter.
// - Any match write clears divider and counter.
// - Select picks ratio; zero stops prescaler.
// - Table for source low bit zero.
// - Count readable; writes to it ignored.
// - Reset clears all fields and registers.
// - Keeps running in wait; wakes processor.
// - Runs in stop modes per source availability.
// - Debug mode freezes count, later resumes.
// - Flag sets on match-to-zero transition.
// - Stopped after reset; slow oscillator default.
module pwc_top (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [pwc_pkg::ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic low_power_osc_1khz_in,
    input wire logic external_ref_clock_in,
    input wire logic internal_ref_clock_in,
    input wire logic debug_halt_in,
    output logic irq_out
);
    logic periodic_event_flag_r;
    logic [1:0] tick_source_select_r;
    logic periodic_irq_enable_r;
    logic [3:0] divider_select_r;
    logic [7:0] tick_count_r;
    logic [7:0] match_limit_r;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] prev_r;
    logic halt1_r;
    logic halt_r;
    logic src_tick;
    logic pulse;
    logic restart;
    logic wr_ctrl;
    logic wr_match;
    logic flag_set;
    logic flag_clr;

    assign wr_ctrl = wr_in && addr_in == pwc_pkg::OFS_CTRL;
    assign wr_match = wr_in && addr_in == pwc_pkg::OFS_MATCH;

    // A new source or ratio, or any match write, restarts the chain from zero.
    assign restart = (wr_ctrl && wdata_in[pwc_pkg::SRC_HI:pwc_pkg::SRC_LO] != tick_source_select_r)
        || (wr_ctrl && wdata_in[pwc_pkg::SEL_HI:pwc_pkg::SEL_LO] != divider_select_r)
        || wr_match;

    // Two-stage synchronisers for the three source clocks and the debug halt level.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clk_in) begin
                if (srst_in) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    prev_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= (gi == 0) ? low_power_osc_1khz_in :
                                   (gi == 1) ? external_ref_clock_in : internal_ref_clock_in;
                    sync2_r[gi] <= sync1_r[gi];
                    prev_r[gi] <= sync2_r[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            halt1_r <= 1'b0;
            halt_r <= 1'b0;
        end else begin
            halt1_r <= debug_halt_in;
            halt_r <= halt1_r;
        end
    end

    // Source mux on synchronised rising edges; codes 1x both pick the internal clock.
    always_comb begin
        case (tick_source_select_r)
            pwc_pkg::SRC_LPO: src_tick = sync2_r[0] && !prev_r[0];
            pwc_pkg::SRC_EXT: src_tick = sync2_r[1] && !prev_r[1];
            default: src_tick = sync2_r[2] && !prev_r[2];
        endcase
    end

    // Wait and stop modes do not gate this block: it runs while its source toggles.
    pwc_divider u_div (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .clear_in(restart),
        .freeze_in(halt_r),
        .tick_in(src_tick),
        .table_in(tick_source_select_r[0]),
        .sel_in(divider_select_r),
        .pulse_out(pulse)
    );

    // Control fields; reset selects the slow oscillator and an off prescaler.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tick_source_select_r <= pwc_pkg::SRC_LPO;
            periodic_irq_enable_r <= 1'b0;
            divider_select_r <= pwc_pkg::SEL_OFF;
        end else if (wr_ctrl) begin
            tick_source_select_r <= wdata_in[pwc_pkg::SRC_HI:pwc_pkg::SRC_LO];
            periodic_irq_enable_r <= wdata_in[pwc_pkg::IE_BIT];
            divider_select_r <= wdata_in[pwc_pkg::SEL_HI:pwc_pkg::SEL_LO];
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            match_limit_r <= pwc_pkg::ZERO8;
        end else if (wr_match) begin
            match_limit_r <= wdata_in;
        end
    end

    // Counter steps on each pulse, wrapping to zero after the match value.
    assign flag_set = pulse && !restart && tick_count_r == match_limit_r;
    always_ff @(posedge clk_in) begin
        if (srst_in || restart) begin
            tick_count_r <= pwc_pkg::ZERO8;
        end else if (pulse) begin
            if (tick_count_r == match_limit_r) begin
                tick_count_r <= pwc_pkg::ZERO8;
            end else begin
                tick_count_r <= tick_count_r + 8'h01;
            end
        end
    end

    // Flag clear is write-one; a simultaneous set wins so no event is dropped.
    assign flag_clr = wr_ctrl && wdata_in[pwc_pkg::FLAG_BIT];
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            periodic_event_flag_r <= 1'b0;
        end else if (flag_set) begin
            periodic_event_flag_r <= 1'b1;
        end else if (flag_clr) begin
            periodic_event_flag_r <= 1'b0;
        end
    end

    // Request is registered from the next flag and enable, so it changes on the same edge as them.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= (periodic_event_flag_r || flag_set) && !(flag_clr && !flag_set)
                       && (wr_ctrl ? wdata_in[pwc_pkg::IE_BIT] : periodic_irq_enable_r);
        end
    end

    // Read data valid only in the cycle after the read strobe; count is read-only.
    always_ff @(posedge clk_in) begin
        if (srst_in || !rd_in) begin
            rdata_out <= pwc_pkg::ZERO8;
        end else begin
            case (addr_in)
                pwc_pkg::OFS_CTRL: rdata_out <= {periodic_event_flag_r, tick_source_select_r,
                                                periodic_irq_enable_r, divider_select_r};
                pwc_pkg::OFS_COUNT: rdata_out <= tick_count_r;
                pwc_pkg::OFS_MATCH: rdata_out <= match_limit_r;
                default: rdata_out <= pwc_pkg::ZERO8;
            endcase
        end
    end

    // Request and counter checks; the request is a pure function of the stored flag and enable.
    irq_follow_a: assert property (@(posedge clk_in) disable iff (srst_in)
        irq_out == (periodic_event_flag_r && periodic_irq_enable_r))
        else $error("irq does not follow flag and enable");
    irq_clear_a: assert property (@(posedge clk_in) disable iff (srst_in)
        flag_clr && !flag_set |=> !irq_out)
        else $error("irq stayed up after flag clear");
    flag_wrap_a: assert property (@(posedge clk_in) disable iff (srst_in)
        pulse && !restart && tick_count_r == match_limit_r |=> periodic_event_flag_r && tick_count_r == 8'h00)
        else $error("match did not wrap and flag");
    count_step_a: assert property (@(posedge clk_in) disable iff (srst_in)
        pulse && !restart && tick_count_r != match_limit_r |=> tick_count_r == $past(tick_count_r) + 8'h01)
        else $error("count did not step");
    count_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !pulse && !restart |=> $stable(tick_count_r))
        else $error("count moved without pulse");
    match_clear_a: assert property (@(posedge clk_in) disable iff (srst_in)
        wr_match |=> tick_count_r == 8'h00 && !pulse)
        else $error("match write did not clear");
    src_clear_a: assert property (@(posedge clk_in) disable iff (srst_in)
        wr_ctrl && wdata_in[pwc_pkg::SRC_HI:pwc_pkg::SRC_LO] != tick_source_select_r |=> tick_count_r == 8'h00)
        else $error("source change did not clear");
    sel_clear_a: assert property (@(posedge clk_in) disable iff (srst_in)
        wr_ctrl && wdata_in[pwc_pkg::SEL_HI:pwc_pkg::SEL_LO] != divider_select_r |=> tick_count_r == 8'h00)
        else $error("select change did not clear");
    flag_clear_a: assert property (@(posedge clk_in) disable iff (srst_in)
        flag_clr && !flag_set |=> !periodic_event_flag_r)
        else $error("write one did not clear flag");
    set_wins_a: assert property (@(posedge clk_in) disable iff (srst_in)
        flag_set && flag_clr |=> periodic_event_flag_r)
        else $error("clear beat a set");
    off_stop_a: assert property (@(posedge clk_in) disable iff (srst_in)
        divider_select_r == pwc_pkg::SEL_OFF |-> !pulse)
        else $error("pulse while prescaler off");
    halt_freeze_a: assert property (@(posedge clk_in) disable iff (srst_in)
        halt_r && $past(halt_r) && !restart |=> $stable(tick_count_r))
        else $error("count moved in debug halt");

    // A halted prescaler must not emit a pulse on the next edge either.
    halt_pulse_a: assert property (@(posedge clk_in) disable iff (srst_in)
        halt_r |=> !pulse)
        else $error("pulse during debug halt");
    // The count can never pass the limit, because every limit write restarts it.
    count_bound_a: assert property (@(posedge clk_in) disable iff (srst_in)
        tick_count_r <= match_limit_r)
        else $error("count above match limit");
    zero_match_a: assert property (@(posedge clk_in) disable iff (srst_in)
        pulse && !restart && match_limit_r == pwc_pkg::ZERO8 |=> periodic_event_flag_r)
        else $error("zero limit pulse did not flag");
    // The flag only rises on the edge that takes the count from the limit to zero.
    flag_rise_a: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(periodic_event_flag_r) |-> $past(pulse && tick_count_r == match_limit_r))
        else $error("flag rose without a wrap");
    flag_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !flag_set && !flag_clr |=> $stable(periodic_event_flag_r))
        else $error("flag moved without set or clear");
    src_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !wr_ctrl |=> $stable(tick_source_select_r))
        else $error("source field moved without write");
    match_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !wr_match |=> $stable(match_limit_r))
        else $error("match limit moved without write");
    // Reset is checked without the disable so that its own effect is watched.
    reset_clear_a: assert property (@(posedge clk_in)
        srst_in |=> tick_count_r == pwc_pkg::ZERO8 && match_limit_r == pwc_pkg::ZERO8
        && !periodic_event_flag_r && !periodic_irq_enable_r && !irq_out
        && divider_select_r == pwc_pkg::SEL_OFF && tick_source_select_r == pwc_pkg::SRC_LPO)
        else $error("reset left state behind");
    // Read port: data stands for one cycle only and carries the sampled register.
    rdata_idle_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !rd_in |=> rdata_out == pwc_pkg::ZERO8)
        else $error("read data without read strobe");
    count_read_a: assert property (@(posedge clk_in) disable iff (srst_in)
        rd_in && addr_in == pwc_pkg::OFS_COUNT |=> rdata_out == $past(tick_count_r))
        else $error("count read wrong");
    match_read_a: assert property (@(posedge clk_in) disable iff (srst_in)
        rd_in && addr_in == pwc_pkg::OFS_MATCH |=> rdata_out == $past(match_limit_r))
        else $error("match limit read wrong");
    flag_read_a: assert property (@(posedge clk_in) disable iff (srst_in)
        rd_in && addr_in == pwc_pkg::OFS_CTRL |=> rdata_out[pwc_pkg::FLAG_BIT] == $past(periodic_event_flag_r))
        else $error("flag read wrong");
endmodule // pwc_top

// >>> tb/pwc_top_test.sv
// Purpose: Self-checking bench for the periodic wakeup counter, driven through its register port.
// Assumes: Source clocks are slow levels, held three bus cycles high and three low per tick.
// Notes: Select 8 with source low bit 0 divides by one, so most tests step the count tick by tick.
`timescale 1ns/1ps
module pwc_top_test;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [pwc_pkg::ADDR_W-1:0] addr_in = '0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic [2:0] src_lvl = 3'b000;
    logic debug_halt_in = 1'b0;
    logic irq_out;
    int fails = 0;
    int checks_done = 0;

    // Free-running 200 MHz bus clock.
    always #2.5 clk_in = ~clk_in;

    pwc_top u_dut (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .rdata_out(rdata_out),
        .low_power_osc_1khz_in(src_lvl[0]),
        .external_ref_clock_in(src_lvl[1]),
        .internal_ref_clock_in(src_lvl[2]),
        .debug_halt_in(debug_halt_in),
        .irq_out(irq_out)
    );

    // Prints the counts and the verdict, then stops the run.
    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One-cycle write strobe beside address and data.
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    // Read strobe for one cycle; data is looked at in the single cycle where it stands.
    task automatic chk_rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        checks_done++;
        if (rdata_out !== exp) begin
            fails++;
            $display("wrong value at %0t: reg %0d read %h, expected %h", $time, a, rdata_out, exp);
        end
    endtask

    // Interrupt level, sampled two edges on; the request changes on the same edge as flag and enable.
    task automatic chk_irq(input logic exp);
        repeat (2) @(posedge clk_in);
        #1;
        checks_done++;
        if (irq_out !== exp) begin
            fails++;
            $display("wrong value at %0t: irq %b, expected %b", $time, irq_out, exp);
        end
    endtask

    // Rising edges on one source, then time for sync, prescaler and count to settle.
    task automatic tick(input int idx, input int n);
        @(posedge clk_in);
        repeat (n) begin
            src_lvl[idx] <= 1'b1;
            repeat (3) @(posedge clk_in);
            src_lvl[idx] <= 1'b0;
            repeat (3) @(posedge clk_in);
        end
        repeat (8) @(posedge clk_in);
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, fails);
    endtask

    // Cuts a hang short; the tests need about 6,500 cycles.
    initial begin
        #200000;
        fails++;
        $display("wrong value at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        // Reset state, and the counter must stay stopped with select at zero.
        chk_rd(pwc_pkg::OFS_CTRL, 8'h00);
        chk_rd(pwc_pkg::OFS_MATCH, 8'h00);
        tick(0, 3);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h00);
        wr(2'h3, 8'hFF);
        chk_rd(2'h3, 8'h00);
        end_test("reset");
        // Wrap at match 3: the flag waits for the step back to zero.
        wr(pwc_pkg::OFS_CTRL, 8'h08);
        wr(pwc_pkg::OFS_MATCH, 8'h03);
        tick(0, 3);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h03);
        chk_rd(pwc_pkg::OFS_CTRL, 8'h08);
        tick(0, 1);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h00);
        chk_rd(pwc_pkg::OFS_CTRL, 8'h88);
        chk_irq(1'b0);
        tick(0, 2);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h02);
        end_test("wrap");
        // Enable, write zero to the flag, then write one to clear it.
        wr(pwc_pkg::OFS_CTRL, 8'h18);
        chk_irq(1'b1);
        chk_rd(pwc_pkg::OFS_CTRL, 8'h98);
        wr(pwc_pkg::OFS_CTRL, 8'h98);
        chk_rd(pwc_pkg::OFS_CTRL, 8'h18);
        chk_irq(1'b0);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h02);
        wr(pwc_pkg::OFS_COUNT, 8'h55);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h02);
        wr(pwc_pkg::OFS_MATCH, 8'h03);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h00);
        end_test("flag");
        // A changed select, then a changed source, each restart the count.
        tick(0, 2);
        wr(pwc_pkg::OFS_CTRL, 8'h19);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h00);
        tick(0, 4);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h02);
        wr(pwc_pkg::OFS_CTRL, 8'h59);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h00);
        tick(0, 4);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h00);
        tick(2, 4);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h02);
        end_test("restart");
        // Match zero raises the flag on every prescaler pulse.
        wr(pwc_pkg::OFS_CTRL, 8'hD8);
        wr(pwc_pkg::OFS_MATCH, 8'h00);
        tick(2, 1);
        chk_rd(pwc_pkg::OFS_CTRL, 8'hD8);
        chk_irq(1'b1);
        wr(pwc_pkg::OFS_CTRL, 8'hD8);
        chk_irq(1'b0);
        tick(2, 1);
        chk_rd(pwc_pkg::OFS_CTRL, 8'hD8);
        // A write-one clear sampled on the very edge that sets the flag must lose.
        wr(pwc_pkg::OFS_CTRL, 8'hD8);
        chk_rd(pwc_pkg::OFS_CTRL, 8'h58);
        fork
            tick(2, 1);
            begin
                repeat (3) @(posedge clk_in);
                wr(pwc_pkg::OFS_CTRL, 8'hD8);
            end
        join
        chk_rd(pwc_pkg::OFS_CTRL, 8'hD8);
        chk_irq(1'b1);
        end_test("match_zero");
        // External source with source low bit 1: select 8 divides by 1000.
        wr(pwc_pkg::OFS_CTRL, 8'hA8);
        wr(pwc_pkg::OFS_MATCH, 8'h05);
        tick(1, 999);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h00);
        tick(1, 1);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h01);
        wr(pwc_pkg::OFS_CTRL, 8'hE8);
        chk_rd(pwc_pkg::OFS_CTRL, 8'h68);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h00);
        end_test("table_one");
        // Debug halt holds the count; counting resumes from the held value.
        wr(pwc_pkg::OFS_CTRL, 8'h08);
        tick(0, 2);
        debug_halt_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        tick(0, 3);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h02);
        @(posedge clk_in);
        debug_halt_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        tick(0, 1);
        chk_rd(pwc_pkg::OFS_COUNT, 8'h03);
        end_test("debug");
        close_out();
    end
endmodule // pwc_top_test
